// File: rtl/toip_dev.sv
// device end: port clock, frame timing, bit capture and byte fifo
`timescale 1ns/1ps
`default_nettype none
`include "toip_map.svh"

module toip_fifo #(
  parameter int WIDTH = `TOIP_WORD_W,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic out_valid, // word available
  input wire logic out_ready, // word taken
  output logic [WIDTH-1:0] out_data // word out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : toip_fifo

module toip_dev #(
  parameter int HALF_DIV = 12,
  parameter int FRAME_PERIODS = 256,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk, // 200 MHz system clock
  input wire logic rst, // async reset, high
  toip_if.dev link, // overhead port pins
  input wire logic sw_ins_en, // software insertion enabled
  output logic out_valid, // overhead byte available
  input wire logic out_ready, // overhead byte taken
  output logic [`TOIP_WORD_W-1:0] out_data // {ext, index, byte}
);
  localparam int DW = $clog2(HALF_DIV);
  localparam int PW = $clog2(FRAME_PERIODS);
  localparam logic [DW-1:0] DIV_LAST = DW'(HALF_DIV - 1);
  localparam logic [PW-1:0] POS_LAST = PW'(FRAME_PERIODS - 1);
  localparam logic [PW-1:0] POS_RESET = PW'(FRAME_PERIODS - 2);

  logic [1:0] ins_sy;
  logic [1:0] dat_sy;
  logic [1:0] line_sy;
  logic [1:0] sect_sy;
  logic [DW-1:0] div_cnt;
  logic port_clk;
  logic stall;
  logic tick;
  logic fall_ev;
  logic [PW-1:0] pos;
  logic [PW-1:0] next_pos;
  logic port_ready;
  logic frame_pulse;
  logic line_req;
  logic sect_req;
  logic [`TOIP_BYTE_BITS-2:0] byte_sr;
  logic byte_ext;
  logic in_toh;
  logic [`TOIP_IDX_W-1:0] cur_idx;
  logic [`TOIP_IDX_W-1:0] nxt_idx;
  toip_pkg::toip_cls_t cur_cls;
  toip_pkg::toip_cls_t nxt_cls;
  logic take_bit;
  logic took_ext;
  logic pend_valid;
  logic pend_ready;
  logic [`TOIP_WORD_W-1:0] pend_data;

  function automatic toip_pkg::toip_cls_t byte_cls(input logic [`TOIP_IDX_W-1:0] idx);
    if (idx >= `TOIP_SECT_FIRST && idx <= `TOIP_SECT_LAST) begin
      return toip_pkg::cls_sect;
    end else if (idx >= `TOIP_LINE_FIRST && idx <= `TOIP_LINE_LAST) begin
      return toip_pkg::cls_line;
    end else if (idx == `TOIP_E1_IDX || idx == `TOIP_F1_IDX || idx == `TOIP_E2_IDX) begin
      return toip_pkg::cls_talk;
    end else begin
      return toip_pkg::cls_plain;
    end
  endfunction : byte_cls

  // two-stage synchronisers for the pins driven by the source
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ins_sy <= 2'h0;
      dat_sy <= 2'h0;
      line_sy <= 2'h0;
      sect_sy <= 2'h0;
    end else begin
      ins_sy <= {ins_sy[0], link.ovh_insert_en};
      dat_sy <= {dat_sy[0], link.ovh_serial_in};
      line_sy <= {line_sy[0], link.line_chan_serial_in};
      sect_sy <= {sect_sy[0], link.sect_chan_serial_in};
    end
  end

  // clock parks low while a finished byte waits for fifo room
  assign stall = pend_valid && !port_clk;
  assign tick = (div_cnt == DIV_LAST) && !stall;
  assign fall_ev = tick && port_clk;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
    end else if (stall) begin
      div_cnt <= div_cnt;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_clk <= 1'b0;
    end else if (tick) begin
      port_clk <= !port_clk;
    end
  end

  assign next_pos = (pos == POS_LAST) ? '0 : pos + 1'b1;
  assign in_toh = pos < PW'(`TOIP_TOH_BITS);
  assign cur_idx = `TOIP_IDX_W'(pos >> 3);
  assign nxt_idx = `TOIP_IDX_W'(next_pos >> 3);
  assign cur_cls = byte_cls(cur_idx);
  assign nxt_cls = byte_cls(nxt_idx);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pos <= POS_RESET;
    end else if (fall_ev) begin
      pos <= next_pos;
    end
  end

  // outputs for the next bit period change on the falling edge, in the same ref_clk cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_ready <= 1'b0;
      frame_pulse <= 1'b0;
      line_req <= 1'b0;
      sect_req <= 1'b0;
    end else if (fall_ev) begin
      port_ready <= next_pos < PW'(`TOIP_TOH_BITS);
      // pulse in last period of frame
      frame_pulse <= next_pos == POS_LAST;
      line_req <= (next_pos < PW'(`TOIP_TOH_BITS)) && nxt_cls == toip_pkg::cls_line;
      sect_req <= (next_pos < PW'(`TOIP_TOH_BITS)) && nxt_cls == toip_pkg::cls_sect;
    end
  end

  always_comb begin
    took_ext = 1'b0;
    take_bit = 1'b0;
    // sample the data pin with ready and insert
    if (port_ready && ins_sy[1]) begin
      took_ext = 1'b1;
      take_bit = dat_sy[1];
    // plain bytes with insert and software low
    end else if (cur_cls == toip_pkg::cls_plain && !ins_sy[1] && !sw_ins_en) begin
      took_ext = 1'b1;
      take_bit = dat_sy[1];
    end else if (line_req) begin
      took_ext = 1'b1;
      take_bit = line_sy[1];
    end else if (sect_req) begin
      took_ext = 1'b1;
      take_bit = sect_sy[1];
    end
  end

  // capture on falling edge of port clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      byte_sr <= '0;
      byte_ext <= 1'b0;
    end else if (fall_ev && in_toh) begin
      if (pos[2:0] == `TOIP_LAST_BIT) begin
        byte_sr <= '0;
        byte_ext <= 1'b0;
      end else begin
        byte_sr <= {byte_sr[`TOIP_BYTE_BITS-3:0], take_bit};
        byte_ext <= byte_ext || took_ext;
      end
    end
  end

  // bytes are the first STS-1 overhead only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_valid <= 1'b0;
      pend_data <= '0;
    end else if (fall_ev && in_toh && pos[2:0] == `TOIP_LAST_BIT) begin
      pend_valid <= 1'b1;
      pend_data <= {byte_ext || took_ext, cur_idx, byte_sr, take_bit};
    end else if (pend_ready) begin
      pend_valid <= 1'b0;
    end
  end

  toip_fifo #(.WIDTH(`TOIP_WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(pend_valid),
    .in_ready(pend_ready),
    .in_data(pend_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  assign link.ovh_port_clk = port_clk;
  assign link.ovh_port_ready = port_ready;
  assign link.ovh_frame_pulse = frame_pulse;
  assign link.line_chan_req = line_req;
  assign link.sect_chan_req = sect_req;
endmodule : toip_dev
`default_nettype wire

// File: rtl/toip_map.svh
// overhead port constants: byte positions, bit counts, word widths
`ifndef TOIP_MAP_SVH
`define TOIP_MAP_SVH
`define TOIP_BYTE_BITS 8
`define TOIP_TOH_BYTES 27
`define TOIP_TOH_BITS 216
`define TOIP_IDX_W 5
`define TOIP_SECT_FIRST 5'h06
`define TOIP_SECT_LAST 5'h08
`define TOIP_LINE_FIRST 5'h0f
`define TOIP_LINE_LAST 5'h17
`define TOIP_E1_IDX 5'h04
`define TOIP_F1_IDX 5'h05
`define TOIP_E2_IDX 5'h1a
`define TOIP_LAST_BIT 3'h7
`define TOIP_WORD_W 14
`endif

// File: rtl/toip_pkg.sv
// shared types of the overhead insertion port
package toip_pkg;
  typedef enum logic [1:0] {
    cls_plain,
    cls_talk,
    cls_sect,
    cls_line
  } toip_cls_t;
  typedef enum logic [0:0] {
    src_hunt,
    src_locked
  } toip_src_state_t;
endpackage : toip_pkg

// File: rtl/toip_if.sv
// link between overhead port device end and the external source
`timescale 1ns/1ps
`default_nettype none
interface toip_if;
  logic ovh_port_clk;
  logic ovh_port_ready;
  logic ovh_frame_pulse;
  logic ovh_serial_in;
  logic ovh_insert_en;
  logic line_chan_req;
  logic line_chan_serial_in;
  logic sect_chan_req;
  logic sect_chan_serial_in;
  modport dev (
    output ovh_port_clk, ovh_port_ready, ovh_frame_pulse, line_chan_req, sect_chan_req,
    input ovh_serial_in, ovh_insert_en, line_chan_serial_in, sect_chan_serial_in
  );
  modport src (
    input ovh_port_clk, ovh_port_ready, ovh_frame_pulse, line_chan_req, sect_chan_req,
    output ovh_serial_in, ovh_insert_en, line_chan_serial_in, sect_chan_serial_in
  );
endinterface : toip_if
`default_nettype wire

// File: rtl/toip_src.sv
// source end: feeds overhead and channel bits into the port
`timescale 1ns/1ps
`default_nettype none

module toip_src (
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset, high
  toip_if.src link, // overhead port pins
  input wire logic ovh_ins_req, // user wants to insert overhead
  input wire logic ovh_user_bit, // next overhead bit
  output logic ovh_user_take, // overhead bit consumed, pulse
  input wire logic line_user_bit, // next line channel bit
  output logic line_user_take, // line bit consumed, pulse
  input wire logic sect_user_bit, // next section channel bit
  output logic sect_user_take, // section bit consumed, pulse
  output logic frame_mark // next period is frame bit 0, pulse
);
  logic [2:0] clk_sy;
  logic [1:0] rdy_sy;
  logic [1:0] frm_sy;
  logic [1:0] lrq_sy;
  logic [1:0] srq_sy;
  logic rise;
  logic ins;
  logic dat;
  logic lbit;
  logic sbit;
  toip_pkg::toip_src_state_t state;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_sy <= 3'h0;
      rdy_sy <= 2'h0;
      frm_sy <= 2'h0;
      lrq_sy <= 2'h0;
      srq_sy <= 2'h0;
    end else begin
      clk_sy <= {clk_sy[1:0], link.ovh_port_clk};
      rdy_sy <= {rdy_sy[0], link.ovh_port_ready};
      frm_sy <= {frm_sy[0], link.ovh_frame_pulse};
      lrq_sy <= {lrq_sy[0], link.line_chan_req};
      srq_sy <= {srq_sy[0], link.sect_chan_req};
    end
  end

  // act on each rising port clock edge
  assign rise = clk_sy[1] && !clk_sy[2];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= toip_pkg::src_hunt;
    end else begin
      case (state)
        toip_pkg::src_hunt: begin
          if (rise && frm_sy[1]) begin
            state <= toip_pkg::src_locked;
          end
        end
        default: begin
          state <= toip_pkg::src_locked;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ins <= 1'b0;
      dat <= 1'b0;
      ovh_user_take <= 1'b0;
    end else if (rise) begin
      ins <= ovh_ins_req && rdy_sy[1] && state == toip_pkg::src_locked;
      // launch overhead bit on rising edge
      dat <= ovh_user_bit;
      ovh_user_take <= ovh_ins_req && rdy_sy[1] && state == toip_pkg::src_locked;
    end else begin
      ovh_user_take <= 1'b0;
    end
  end

  // line bit launched while request high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lbit <= 1'b0;
      line_user_take <= 1'b0;
    end else if (rise && lrq_sy[1]) begin
      lbit <= line_user_bit;
      line_user_take <= 1'b1;
    end else begin
      line_user_take <= 1'b0;
    end
  end

  // section bit launched the same way
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sbit <= 1'b0;
      sect_user_take <= 1'b0;
    end else if (rise && srq_sy[1]) begin
      sbit <= sect_user_bit;
      sect_user_take <= 1'b1;
    end else begin
      sect_user_take <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame_mark <= 1'b0;
    end else begin
      frame_mark <= rise && frm_sy[1];
    end
  end

  assign link.ovh_insert_en = ins;
  assign link.ovh_serial_in = dat;
  assign link.line_chan_serial_in = lbit;
  assign link.sect_chan_serial_in = sbit;
endmodule : toip_src
`default_nettype wire

// File: verification/toip_chk_asserts.sv
// timing checks on the overhead port pins
`timescale 1ns/1ps
`default_nettype none
module toip_chk #(
  parameter int FRAME_PERIODS = 256,
  parameter int HALF_DIV = 12
) (
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic ovh_port_clk, // port clock
  input wire logic ovh_port_ready, // port ready
  input wire logic ovh_frame_pulse, // frame indicator
  input wire logic line_chan_req, // line channel request
  input wire logic sect_chan_req // section channel request
);
  logic clk_q;
  logic seen;
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic [15:0] pos;
  // clock phase lengths in ref_clk cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_q <= 1'b0;
      hi_cnt <= 16'h0;
      lo_cnt <= 16'h0;
    end else begin
      clk_q <= ovh_port_clk;
      hi_cnt <= ovh_port_clk ? hi_cnt + 16'h1 : 16'h0;
      lo_cnt <= ovh_port_clk ? 16'h0 : lo_cnt + 16'h1;
    end
  end
  // port periods since the frame pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pos <= 16'h0;
      seen <= 1'b0;
    end else if (clk_q && !ovh_port_clk) begin
      pos <= ovh_frame_pulse ? 16'h0 : pos + 16'h1;
      seen <= seen | ovh_frame_pulse;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_CLK_HIGH: assert property ($fell(ovh_port_clk) |-> hi_cnt == HALF_DIV)
    else $error("port clock high phase wrong");
  AST_CLK_LOW: assert property (seen && $rose(ovh_port_clk) |-> lo_cnt >= HALF_DIV)
    else $error("port clock low phase short");
  AST_PINS_ON_FALL: assert property (($changed(ovh_port_ready)
    || $changed(ovh_frame_pulse) || $changed(line_chan_req) || $changed(sect_chan_req))
    |-> $fell(ovh_port_clk))
    else $error("port output moved off the falling edge");
  AST_FRAME_ONE: assert property ($fell(ovh_port_clk) && $past(ovh_frame_pulse)
    |-> !ovh_frame_pulse)
    else $error("frame pulse longer than one period");
  AST_FRAME_GAP: assert property (seen && $rose(ovh_frame_pulse)
    |-> pos == FRAME_PERIODS - 1)
    else $error("frame pulse spacing wrong");
  AST_READY_START: assert property ($rose(ovh_port_ready) |-> pos == 0)
    else $error("ready not right after frame pulse");
  AST_READY_LEN: assert property ($fell(ovh_port_ready) |-> pos == 216)
    else $error("ready length wrong");
  AST_SECT_START: assert property ($rose(sect_chan_req) |-> pos == 48)
    else $error("section request starts wrong");
  AST_SECT_END: assert property ($fell(sect_chan_req) |-> pos == 72)
    else $error("section request ends wrong");
  AST_LINE_START: assert property ($rose(line_chan_req) |-> pos == 120)
    else $error("line request starts wrong");
  AST_LINE_END: assert property ($fell(line_chan_req) |-> pos == 192)
    else $error("line request ends wrong");
endmodule : toip_chk
`default_nettype wire

// File: verification/toip_test.sv
// bench joining both port ends through the link
`timescale 1ns/1ps
`default_nettype none
`include "toip_map.svh"
module toip_test;
  localparam int FP = 240;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sw_ins_en = 1'b1;
  logic out_ready = 1'b1;
  logic out_valid;
  logic [`TOIP_WORD_W-1:0] out_data;
  logic ovh_ins_req = 1'b0;
  logic ovh_user_bit = 1'b0;
  logic line_user_bit = 1'b0;
  logic sect_user_bit = 1'b0;
  logic ovh_user_take, line_user_take, sect_user_take, frame_mark;
  logic [`TOIP_WORD_W-1:0] got_q[$];
  int miscompares = 0;
  int tests_run = 0;
  int bit_n = 0;
  int line_cnt = 0;
  int sect_cnt = 0;
  int line_seen = 0;
  int sect_seen = 0;
  toip_if toip_if_i ();
  toip_dev #(.FRAME_PERIODS(FP)) toip_dev_i (.ref_clk, .rst, .link(toip_if_i), .sw_ins_en,
    .out_valid, .out_ready, .out_data);
  toip_src toip_src_i (.ref_clk, .rst, .link(toip_if_i), .ovh_ins_req, .ovh_user_bit,
    .ovh_user_take, .line_user_bit, .line_user_take, .sect_user_bit, .sect_user_take,
    .frame_mark);
  toip_chk #(.FRAME_PERIODS(FP), .HALF_DIV(12)) toip_chk_i (.ref_clk, .rst,
    .ovh_port_clk(toip_if_i.ovh_port_clk), .ovh_port_ready(toip_if_i.ovh_port_ready),
    .ovh_frame_pulse(toip_if_i.ovh_frame_pulse), .line_chan_req(toip_if_i.line_chan_req),
    .sect_chan_req(toip_if_i.sect_chan_req));
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1 && out_ready) got_q.push_back(out_data);
  end
  function automatic logic [7:0] pat(input int i);
    return 8'h5a ^ 8'(i);
  endfunction : pat
  function automatic bit is_dcc(input int i);
    return (i >= `TOIP_SECT_FIRST && i <= `TOIP_SECT_LAST) ||
      (i >= `TOIP_LINE_FIRST && i <= `TOIP_LINE_LAST);
  endfunction : is_dcc
  // user bit stream, msb first, restarted at each frame
  always @(negedge ref_clk) begin
    if (frame_mark === 1'b1) begin
      bit_n = 0;
    end else if (ovh_user_take === 1'b1) begin
      bit_n = bit_n + 1;
    end
    ovh_user_bit <= 1'(pat(bit_n / 8) >> (7 - bit_n % 8));
  end
  // channel bits handed out per frame
  always @(negedge ref_clk) begin
    if (frame_mark === 1'b1) begin
      line_seen = line_cnt;
      sect_seen = sect_cnt;
      line_cnt = 0;
      sect_cnt = 0;
    end
    if (line_user_take === 1'b1) line_cnt++;
    if (sect_user_take === 1'b1) sect_cnt++;
  end
  task automatic check(input logic [`TOIP_WORD_W-1:0] seen, input logic [`TOIP_WORD_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic pop(output logic [`TOIP_WORD_W-1:0] w);
    int n;
    n = 0;
    while (got_q.size() == 0 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    w = (got_q.size() == 0) ? 14'h3fff : got_q.pop_front();
  endtask : pop
  // skip words until two frames have ended
  task automatic sync_frame();
    logic [`TOIP_WORD_W-1:0] w;
    for (int k = 0; k < 2; k++) begin
      do begin
        pop(w);
      end while (w[12:8] !== `TOIP_E2_IDX);
    end
  endtask : sync_frame
  // inserted bits fill every byte, after a full fifo
  task automatic t_insert();
    logic [`TOIP_WORD_W-1:0] w;
    ovh_ins_req = 1'b1;
    out_ready = 1'b0;
    repeat (3000) @(negedge ref_clk);
    check({13'h0, out_valid}, 14'h1);
    check({13'h0, toip_if_i.ovh_port_clk}, 14'h0);
    out_ready = 1'b1;
    sync_frame();
    for (int i = 0; i < 27; i++) begin
      pop(w);
      check(w, {1'b1, 5'(i), pat(i)});
    end
  endtask : t_insert
  // only channel bytes come from outside
  task automatic t_chan();
    logic [`TOIP_WORD_W-1:0] w;
    ovh_ins_req = 1'b0;
    line_user_bit = 1'b1;
    sect_user_bit = 1'b1;
    sync_frame();
    for (int i = 0; i < 27; i++) begin
      pop(w);
      check(w, is_dcc(i) ? {1'b1, 5'(i), 8'hff} : {1'b0, 5'(i), 8'h00});
    end
    check(14'(line_seen), 14'h48);
    check(14'(sect_seen), 14'h18);
  endtask : t_chan
  // talk bytes stay untouched with both enables low
  task automatic t_prio();
    logic [`TOIP_WORD_W-1:0] w;
    sw_ins_en = 1'b0;
    line_user_bit = 1'b0;
    sect_user_bit = 1'b0;
    sync_frame();
    for (int i = 0; i < 27; i++) begin
      pop(w);
      if (i == `TOIP_E1_IDX || i == `TOIP_F1_IDX || i == `TOIP_E2_IDX) begin
        check(w, {1'b0, 5'(i), 8'h00});
      end else if (is_dcc(i)) begin
        check(w, {1'b1, 5'(i), 8'h00});
      end else begin
        check(w, {1'b1, 5'(i), 8'h00});
      end
    end
  endtask : t_prio
  task automatic tally_and_finish();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    t_insert();
    t_chan();
    t_prio();
    tally_and_finish();
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule : toip_test
`default_nettype wire
